// file: rtl/ccr_pkg.sv
// Constants for the converter output and alarm control register block.
// Assumes a single 50 MHz internal clock and a decoded write strobe
// from the serial configuration port.
// How it works
// - Bit 15 switches the input pattern checker on.
// - Checker compares eight repeating samples against programmed pattern values.
// - Checker clock is gated off while bit 15 is zero.
// - Bit 14 enables the second datapath clock, its checker and FIFO.
// - Bit 12 clears alarms after 64 consecutive good samples.
// - Bit 11 lets conversion clock loss force the outputs off.
// - Bit 10 lets input word clock loss force the outputs off.
// - Bit 9 lets a FIFO pointer collision force the outputs off.
// - Bit 7 inverts every sample word sent to the first converter.
// - Bit 6 inverts every sample word sent to the second converter.
// - In soft sync mode bit 5 is the source of the one-cycle chip sync pulse.
// - In soft mode only a zero to one change of bit 5 makes a sync pulse.
// - Bit 4 selects software sync instead of the external strobe.
// - Bit 3 enables the FIFO pointers two apart alarm.
// - Bit 2 enables the FIFO pointers one apart alarm.
// - Bit 1 enables the FIFO pointer collision alarm.
// - Register at address one resets to 0x600E.
package ccr_pkg;
    // Register map
    localparam logic [4:0]  CCR_CFG_ADDR = 5'h01;
    localparam logic [15:0] CCR_CFG_RST  = 16'h600E;
    localparam logic [15:0] CCR_RW_MASK  = 16'hFEFE;
    // Field positions
    localparam int CCR_B_CHK_EN   = 15;
    localparam int CCR_B_BCLK_EN  = 14;
    localparam int CCR_B_AUTO_CLR = 12;
    localparam int CCR_B_CONV_OFF = 11;
    localparam int CCR_B_WORD_OFF = 10;
    localparam int CCR_B_COLL_OFF = 9;
    localparam int CCR_B_INV_A    = 7;
    localparam int CCR_B_INV_B    = 6;
    localparam int CCR_B_SOFT_BIT = 5;
    localparam int CCR_B_SOFT_MOD = 4;
    localparam int CCR_B_NEAR_TWO = 3;
    localparam int CCR_B_NEAR_ONE = 2;
    localparam int CCR_B_COLL_ALM = 1;
    // Datapath and checker sizes
    localparam int CCR_DW       = 14;
    localparam int CCR_PAT_LEN  = 8;
    localparam logic [6:0] CCR_GOOD_CNT = 7'h40;
endpackage

// file: rtl/ccr_top.sv
// Output and alarm control register with pattern checker, sync source
// selection, output shutdown and sample inversion.
// Assumes samples, FIFO alarms and clock monitor flags arrive on
// clock_i; only the alignment strobe pin is asynchronous.
`timescale 1ns/1ps
module ccr_top (
    // Clock and reset
    input  wire logic                      clock_i,
    input  wire logic                      rst_b_i,
    // Configuration port write and read
    input  wire logic                      cfg_wr_i,
    input  wire logic [4:0]                cfg_addr_i,
    input  wire logic [15:0]               cfg_wdata_i,
    output logic      [15:0]               cfg_rdata_o,
    // Sample stream and programmed pattern
    input  wire logic                      sample_valid_i,
    input  wire logic [ccr_pkg::CCR_DW-1:0] sample_a_i,
    input  wire logic [ccr_pkg::CCR_DW-1:0] sample_b_i,
    input  wire logic [ccr_pkg::CCR_DW*ccr_pkg::CCR_PAT_LEN-1:0] pattern_i,
    input  wire logic                      align_strobe_i,
    input  wire logic                      alarm_clear_i,
    // Clock monitor and FIFO events
    input  wire logic                      conv_clk_lost_i,
    input  wire logic                      word_clk_lost_i,
    input  wire logic                      collision_i,
    input  wire logic                      near_one_i,
    input  wire logic                      near_two_i,
    // Controls and results
    output logic                           chk_clk_en_o,
    output logic                           b_path_clk_en_o,
    output logic                           chip_sync_o,
    output logic                           out_off_o,
    output logic      [ccr_pkg::CCR_DW-1:0] data_a_o,
    output logic      [ccr_pkg::CCR_DW-1:0] data_b_o,
    output logic      [ccr_pkg::CCR_DW-1:0] fail_a_o,
    output logic      [ccr_pkg::CCR_DW-1:0] fail_b_o,
    output logic      [2:0]                alarm_o
);
    import ccr_pkg::*;

    typedef struct packed {
        logic [15:0]       cfg;
        logic [2:0]        strb_sync;
        logic              strb_lvl;
        logic              soft_prev;
        logic              sync;
        logic [2:0]        idx;
        logic [6:0]        good_cnt;
        logic [CCR_DW-1:0] fail_a;
        logic [CCR_DW-1:0] fail_b;
        logic [2:0]        alarm;
        logic              off;
        logic [CCR_DW-1:0] data_a;
        logic [CCR_DW-1:0] data_b;
        logic              chk_en;
        logic              bclk_en;
        logic [15:0]       rdata;
    } ccr_state_t;

    ccr_state_t st_r;
    ccr_state_t st_nxt;

    logic [CCR_DW-1:0] pat_cur;
    logic [CCR_DW-1:0] miss_a;
    logic [CCR_DW-1:0] miss_b;
    logic              chk_on;
    logic              good;
    logic              auto_clr;
    logic              soft_edge;
    logic              strb_edge;
    logic [2:0]        alm_evt;

    // Pattern word that the current sample should match
    assign pat_cur = pattern_i[st_r.idx*CCR_DW +: CCR_DW];

    // Comparisons only while the checker clock would run
    always_comb begin
        chk_on = st_r.cfg[CCR_B_CHK_EN] & sample_valid_i;
        miss_a = chk_on ? (sample_a_i ^ pat_cur) : '0;
        miss_b = (chk_on & st_r.cfg[CCR_B_BCLK_EN])
               ? (sample_b_i ^ pat_cur) : '0;
        good   = chk_on & ~|miss_a & ~|miss_b;
        auto_clr = st_r.cfg[CCR_B_AUTO_CLR] & good
                 & (st_r.good_cnt == CCR_GOOD_CNT - 7'h01);
    end

    // Sync edges and enabled FIFO alarm events
    always_comb begin
        soft_edge = st_r.cfg[CCR_B_SOFT_BIT] & ~st_r.soft_prev;
        strb_edge = (st_r.strb_sync[1] == st_r.strb_sync[2])
                  & st_r.strb_sync[2] & ~st_r.strb_lvl;
        alm_evt[0] = collision_i & st_r.cfg[CCR_B_COLL_ALM];
        alm_evt[1] = near_one_i  & st_r.cfg[CCR_B_NEAR_ONE];
        alm_evt[2] = near_two_i  & st_r.cfg[CCR_B_NEAR_TWO];
    end

    // Next state of the whole block
    always_comb begin
        st_nxt = st_r;
        // Register write; reserved bits 8 and 0 stay zero
        if (cfg_wr_i && cfg_addr_i == CCR_CFG_ADDR) begin
            st_nxt.cfg = cfg_wdata_i & CCR_RW_MASK;
        end
        st_nxt.rdata = (cfg_addr_i == CCR_CFG_ADDR) ? st_r.cfg : 16'h0000;
        // Strobe pin: only the second and third stages decide the level
        st_nxt.strb_sync = {st_r.strb_sync[1:0], align_strobe_i};
        if (st_r.strb_sync[1] == st_r.strb_sync[2]) begin
            st_nxt.strb_lvl = st_r.strb_sync[2];
        end
        st_nxt.soft_prev = st_r.cfg[CCR_B_SOFT_BIT];
        // Soft mode takes bit 5, else the external strobe
        st_nxt.sync = st_r.cfg[CCR_B_SOFT_MOD]
                    ? soft_edge : strb_edge;
        // Index steps per checked sample; sync marks sample zero
        if (chk_on) begin
            st_nxt.idx = st_r.idx + 3'h1;
        end
        // The sample after the pulse is always pattern word zero
        if (st_r.sync) begin
            st_nxt.idx = 3'h0;
        end
        // Consecutive good sample count
        if (chk_on) begin
            st_nxt.good_cnt = good ? st_r.good_cnt + 7'h01 : 7'h00;
        end
        if (auto_clr || alarm_clear_i) begin
            st_nxt.good_cnt = 7'h00;
            st_nxt.fail_a   = '0;
            st_nxt.fail_b   = '0;
            st_nxt.alarm    = 3'h0;
        end
        // New failures win over a clear in the same cycle
        st_nxt.fail_a = st_nxt.fail_a | miss_a;
        st_nxt.fail_b = st_nxt.fail_b | miss_b;
        st_nxt.alarm  = st_nxt.alarm | alm_evt;
        // Output shutdown sources
        st_nxt.off = (st_r.cfg[CCR_B_CONV_OFF] & conv_clk_lost_i)
                   | (st_r.cfg[CCR_B_WORD_OFF] & word_clk_lost_i)
                   | (st_r.cfg[CCR_B_COLL_OFF] & collision_i);
        // Inversion swaps the sense of the differential outputs
        st_nxt.data_a = sample_a_i ^ {CCR_DW{st_r.cfg[CCR_B_INV_A]}};
        st_nxt.data_b = sample_b_i ^ {CCR_DW{st_r.cfg[CCR_B_INV_B]}};
        // Clock gates follow the freshly written bits
        st_nxt.chk_en  = st_nxt.cfg[CCR_B_CHK_EN];
        st_nxt.bclk_en = st_nxt.cfg[CCR_B_BCLK_EN];
    end

    // State register; reset value puts the documented defaults in place
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r         <= '0;
            st_r.cfg     <= CCR_CFG_RST;
            st_r.bclk_en <= CCR_CFG_RST[CCR_B_BCLK_EN];
            st_r.chk_en  <= CCR_CFG_RST[CCR_B_CHK_EN];
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign cfg_rdata_o     = st_r.rdata;
    assign chk_clk_en_o    = st_r.chk_en;
    assign b_path_clk_en_o = st_r.bclk_en;
    assign chip_sync_o     = st_r.sync;
    assign out_off_o       = st_r.off;
    assign data_a_o        = st_r.data_a;
    assign data_b_o        = st_r.data_b;
    assign fail_a_o        = st_r.fail_a;
    assign fail_b_o        = st_r.fail_b;
    assign alarm_o         = st_r.alarm;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    // Gate follows the enable bit, including a write
    chk_gate_a: assert property (
        st_r.cfg[CCR_B_CHK_EN] == chk_clk_en_o)
        else $error("checker gate differs from enable bit");

    // A disabled checker keeps its results frozen
    chk_frz_a: assert property (
        !st_r.cfg[CCR_B_CHK_EN] && !alarm_clear_i
        |=> $stable(fail_a_o) && $stable(fail_b_o))
        else $error("checker active while disabled");

    // Auto clear may still wipe old second path results
    b_gate_a: assert property (
        !st_r.cfg[CCR_B_BCLK_EN] && !alarm_clear_i && !auto_clr
        |=> $stable(fail_b_o))
        else $error("second path checker ran without clock");

    // Second path mismatch is flagged while its clock runs
    b_miss_a: assert property (
        st_r.cfg[CCR_B_CHK_EN] && st_r.cfg[CCR_B_BCLK_EN]
        && sample_valid_i && sample_b_i != pat_cur
        |=> fail_b_o != '0)
        else $error("second path mismatch not flagged");

    // Index restarts after every sync pulse
    idx_sync_a: assert property (
        chip_sync_o |=> st_r.idx == 3'h0)
        else $error("pattern index not restarted");

    // Index steps once per checked sample
    idx_step_a: assert property (
        !chip_sync_o && st_r.cfg[CCR_B_CHK_EN] && sample_valid_i
        |=> st_r.idx == $past(st_r.idx) + 3'h1)
        else $error("pattern index did not step");

    pat_miss_a: assert property (
        st_r.cfg[CCR_B_CHK_EN] && sample_valid_i && sample_a_i != pat_cur
        |=> (fail_a_o & $past(sample_a_i ^ pat_cur)) != '0)
        else $error("pattern mismatch not flagged");

    soft_rise_a: assert property (
        st_r.cfg[CCR_B_SOFT_MOD] && $rose(st_r.cfg[CCR_B_SOFT_BIT])
        |=> chip_sync_o ##1 !chip_sync_o)
        else $error("soft sync rise gave no single pulse");

    soft_fall_a: assert property (
        st_r.cfg[CCR_B_SOFT_MOD] && !soft_edge |=> !chip_sync_o)
        else $error("sync pulse without soft rise");

    // Strobe mode passes each settled strobe rise as a pulse
    strb_sync_a: assert property (
        !st_r.cfg[CCR_B_SOFT_MOD] && strb_edge |=> chip_sync_o)
        else $error("strobe rise gave no sync pulse");

    // Strobe mode ignores the soft bit
    strb_quiet_a: assert property (
        !st_r.cfg[CCR_B_SOFT_MOD] && !strb_edge |=> !chip_sync_o)
        else $error("sync pulse without strobe rise");

    // A write lands with the reserved bits forced low
    cfg_wr_a: assert property (
        cfg_wr_i && cfg_addr_i == CCR_CFG_ADDR
        |=> st_r.cfg == ($past(cfg_wdata_i) & CCR_RW_MASK))
        else $error("register write did not land");

    // Unmapped addresses read as zero
    rdata_a: assert property (
        cfg_addr_i != CCR_CFG_ADDR |=> cfg_rdata_o == 16'h0000)
        else $error("unmapped address read nonzero");

    auto_clr_a: assert property (
        auto_clr && alm_evt == 3'h0 |=> fail_a_o == '0 && alarm_o == 3'h0)
        else $error("alarms not cleared after good run");

    shut_off_a: assert property (
        (st_r.cfg[CCR_B_COLL_OFF] && collision_i)
        || (st_r.cfg[CCR_B_CONV_OFF] && conv_clk_lost_i)
        || (st_r.cfg[CCR_B_WORD_OFF] && word_clk_lost_i)
        |=> out_off_o)
        else $error("outputs not forced off");

    // Conversion clock loss alone shuts the outputs
    conv_off_a: assert property (
        st_r.cfg[CCR_B_CONV_OFF] && conv_clk_lost_i |=> out_off_o)
        else $error("conversion clock loss ignored");

    // Word clock loss alone shuts the outputs
    word_off_a: assert property (
        st_r.cfg[CCR_B_WORD_OFF] && word_clk_lost_i |=> out_off_o)
        else $error("word clock loss ignored");

    // Without an enabled cause the outputs stay on
    no_off_a: assert property (
        !(st_r.cfg[CCR_B_COLL_OFF] && collision_i)
        && !(st_r.cfg[CCR_B_CONV_OFF] && conv_clk_lost_i)
        && !(st_r.cfg[CCR_B_WORD_OFF] && word_clk_lost_i)
        |=> !out_off_o)
        else $error("outputs off without a cause");

    invert_a_a: assert property (
        st_r.cfg[CCR_B_INV_A] |=> data_a_o == ~$past(sample_a_i))
        else $error("first converter data not inverted");

    invert_b_a: assert property (
        !st_r.cfg[CCR_B_INV_B] |=> data_b_o == $past(sample_b_i))
        else $error("second converter data altered");

    coll_alarm_a: assert property (
        collision_i && st_r.cfg[CCR_B_COLL_ALM] |=> alarm_o[0] [*1])
        else $error("collision alarm missed");

    near_alarm_a: assert property (
        near_two_i && !st_r.cfg[CCR_B_NEAR_TWO] && !alarm_o[2]
        && !st_r.cfg[CCR_B_NEAR_ONE] && near_one_i |=> !alarm_o[2])
        else $error("disabled near alarm raised");

    // Enabled one apart event sets its sticky bit
    near_one_a: assert property (
        near_one_i && st_r.cfg[CCR_B_NEAR_ONE] |=> alarm_o[1])
        else $error("one apart alarm missed");

    // Enabled two apart event sets its sticky bit
    near_two_a: assert property (
        near_two_i && st_r.cfg[CCR_B_NEAR_TWO] |=> alarm_o[2])
        else $error("two apart alarm missed");
endmodule

// file: dv/ccr_host.sv
// Host model: writes and selects the configuration port.
// Assumes its tasks are entered at a falling edge of clock_i.
`timescale 1ns/1ps
module ccr_host (
    // Clock
    input  wire logic        clock_i,
    // Configuration port drive
    output logic             cfg_wr_o,
    output logic [4:0]       cfg_addr_o,
    output logic [15:0]      cfg_wdata_o
);
    // Idle: unmapped address, no strobe
    initial begin
        cfg_wr_o    = 1'b0;
        cfg_addr_o  = 5'h1f;
        cfg_wdata_o = 16'h0000;
    end
    // One write over one rising edge, then one idle edge before return
    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        cfg_wr_o    = 1'b1;
        cfg_addr_o  = a;
        cfg_wdata_o = d;
        @(negedge clock_i);
        cfg_wr_o    = 1'b0;
        cfg_wdata_o = ~d;
        @(negedge clock_i);
    endtask
    // Select an address; read data is registered by the next edge
    task automatic rd_sel(input logic [4:0] a);
        cfg_addr_o = a;
        @(negedge clock_i);
    endtask
endmodule

// file: dv/tb.sv
// Self-checking bench for the output and alarm control register.
// Assumes a 50 MHz clock; inputs change at the falling edge.
`timescale 1ns/1ps
module tb;
    import ccr_pkg::*;
    logic clock_i, rst_b_i, cfg_wr, valid, clr, strobe;
    logic conv, word, coll, n1, n2, chk_en, b_en, sync, off;
    logic [4:0]  addr;
    logic [15:0] wdata, rdata, d;
    logic [2:0]  alarm;
    logic [CCR_DW-1:0] sa, sb, da, db, fa, fb, m;
    logic [CCR_DW*CCR_PAT_LEN-1:0] pat;
    int fail_count, checked, seed, hits;

    ccr_host host (.clock_i(clock_i), .cfg_wr_o(cfg_wr),
        .cfg_addr_o(addr), .cfg_wdata_o(wdata));
    ccr_top DUT (.clock_i(clock_i), .rst_b_i(rst_b_i), .cfg_wr_i(cfg_wr),
        .cfg_addr_i(addr), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata),
        .sample_valid_i(valid), .sample_a_i(sa), .sample_b_i(sb),
        .pattern_i(pat), .align_strobe_i(strobe), .alarm_clear_i(clr),
        .conv_clk_lost_i(conv), .word_clk_lost_i(word),
        .collision_i(coll), .near_one_i(n1), .near_two_i(n2),
        .chk_clk_en_o(chk_en), .b_path_clk_en_o(b_en),
        .chip_sync_o(sync), .out_off_o(off), .data_a_o(da), .data_b_o(db),
        .fail_a_o(fa), .fail_b_o(fb), .alarm_o(alarm));

    // Compare one result, zero-extended to a word
    task automatic cmp(string nm, logic [15:0] exp, logic [15:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    function automatic logic [CCR_DW-1:0] pword(int k);
        return pat[CCR_DW*k +: CCR_DW];
    endfunction
    task automatic cyc(int n);
        repeat (n) @(negedge clock_i);
    endtask
    task automatic wr(logic [15:0] v);
        host.wr_reg(CCR_CFG_ADDR, v);
    endtask
    task automatic rd(logic [15:0] e);
        host.rd_sel(CCR_CFG_ADDR);
        cmp("cfg_rdata", e, rdata);
    endtask
    // Count sync pulses over a window wider than the four-cycle strobe latency
    task automatic syncs(logic [15:0] e);
        hits = 0;
        repeat (6) begin
            if (sync === 1'b1) hits++;
            @(negedge clock_i);
        end
        cmp("sync_pulses", e, 16'(hits));
    endtask
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    // Whole run is well under a thousand cycles
    initial begin
        #(20 * 3000);
        fail_count++;
        complete_run();
    end
    initial begin
        {rst_b_i, valid, clr, strobe, conv, word, coll, n1, n2} = '0;
        sa = '0;
        sb = '0;
        fail_count = 0;
        checked = 0;
        seed = $urandom(32'h754a);
        pat = 112'({$urandom, $urandom, $urandom, $urandom});
        cyc(8);
        rst_b_i = 1'b1;
        rd(CCR_CFG_RST);
        cmp("b_clk_en", 1, 16'(b_en));
        // Random writes, with an unmapped write in between
        repeat (6) begin
            d = 16'($urandom);
            wr(d);
            cmp("chk_clk_en", 16'(d[15]), 16'(chk_en));
            cmp("b_clk_en", 16'(d[14]), 16'(b_en));
            host.wr_reg(5'h02, ~d);
            rd(d & CCR_RW_MASK);
        end
        host.rd_sel(5'h02);
        cmp("rdata_unmapped", 0, rdata);
        // Inversion per channel, all four combinations
        for (int k = 0; k < 4; k++) begin
            wr({8'h00, 2'(k), 6'h00});
            sa = 14'($urandom);
            sb = 14'($urandom);
            cyc(2);
            cmp("data_a", 16'(sa ^ {14{k[1]}}), 16'(da));
            cmp("data_b", 16'(sb ^ {14{k[0]}}), 16'(db));
        end
        // Each shutdown cause, enabled then disabled
        for (int k = 0; k < 3; k++) begin
            wr(16'h0800 >> k);
            {conv, word, coll} = 3'b100 >> k;
            cyc(1);
            cmp("out_off", 1, 16'(off));
            wr(16'h0000);
            cyc(1);
            cmp("out_off_masked", 0, 16'(off));
            {conv, word, coll} = 3'b000;
        end
        cmp("alarm_masked", 0, 16'(alarm));
        // Each FIFO alarm: one-cycle event, sticky until cleared
        for (int k = 0; k < 3; k++) begin
            wr(16'h0002 << k);
            {n2, n1, coll} = 3'b001 << k;
            cyc(1);
            {n2, n1, coll} = 3'b000;
            cyc(1);
            cmp("alarm", 16'(3'b001 << k), 16'(alarm));
            clr = 1'b1;
            cyc(1);
            clr = 1'b0;
        end
        // Software sync: only a rise of the bit in soft mode pulses once
        wr(16'h0020);
        syncs(0);
        wr(16'h0010);
        wr(16'h0030);
        syncs(1);
        wr(16'h0010);
        syncs(0);
        // Strobe mode: only the settled rise of the pin pulses
        wr(16'h0000);
        strobe = 1'b1;
        syncs(1);
        strobe = 1'b0;
        syncs(0);
        // Checker off: a bad sample leaves no trace
        sa = ~pword(0);
        valid = 1'b1;
        cyc(2);
        valid = 1'b0;
        cmp("fail_a_off", 0, 16'(fa));
        // Source starts the pattern four idle cycles after the sync write
        wr(16'hD010);
        wr(16'hD030);
        cyc(4);
        valid = 1'b1;
        for (int k = 0; k < 8; k++) begin
            sa = pword(k);
            sb = pword(k);
            cyc(1);
        end
        m = 14'(1 << ($urandom % 14));
        sa = pword(0) ^ m;
        sb = pword(0) ^ m;
        cyc(1);
        valid = 1'b0;
        cyc(1);
        cmp("fail_a", 16'(m), 16'(fa));
        cmp("fail_b", 16'(m), 16'(fb));
        // 63 good samples keep the failure, the 64th clears it
        valid = 1'b1;
        for (int k = 1; k < 64; k++) begin
            sa = pword(k % 8);
            sb = pword(k % 8);
            cyc(1);
        end
        valid = 1'b0;
        cyc(2);
        cmp("fail_a_held", 16'(m), 16'(fa));
        valid = 1'b1;
        sa = pword(0);
        sb = pword(0);
        cyc(1);
        valid = 1'b0;
        cyc(2);
        cmp("fail_a_auto", 0, 16'(fa));
        cmp("fail_b_auto", 0, 16'(fb));
        complete_run();
    end
endmodule
